// ==== design/rsq_reset_sequencer.sv ====
// Purpose: reset sequencing of the controller core, ports and reset pin
// Assumes: clk is the internal oscillator clock; stop_exit and pin config are on clk
// Notes: vector memory returns data one cycle after a read request
module rsq_reset_sequencer
  import rsq_pkg::*;
#(
  parameter int HOLD_XTAL_CYC = HOLD_XTAL_DEF
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // reset sources and crystal option
  input wire logic supply_above_por,
  input wire logic supply_brownout_detect,
  input wire logic wdt_timeout,
  input wire logic stop_exit,
  input wire logic xtal_opt_en,
  // reset-shared pin
  input wire logic reset_shared_port_pin_in,
  output logic reset_shared_port_pin_out,
  output logic reset_shared_port_pin_oe_n,
  // pin configuration from software
  input wire logic pin_cfg_wr,
  input wire logic pin_cfg_gpio,
  input wire logic pin_gpio_out_val,
  // reset controls
  output logic cpu_reset,
  output logic periph_idle,
  output logic ctrl_reg_init,
  output logic wdt_oscillator_control_reg_init,
  output logic sysclk_ipo_sel,
  output logic port_reset,
  output logic gpio_force_input,
  output logic gpio_pullup_off,
  output logic gpio_altfn_off,
  output logic xtal_osc_run,
  output logic wdt_osc_run,
  // reset vector fetch
  output logic [15:0] vec_addr,
  output logic vec_rd,
  input wire logic [7:0] vec_data,
  output logic [15:0] pc_value,
  output logic pc_load
);
  localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_SHORT_LAST = CNT_W'(HOLD_SHORT_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_XTAL_LAST = CNT_W'(HOLD_XTAL_CYC - 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(PIN_SETTLE_CYC - 1);
  // sync reset state: pin high, supply above threshold, no brownout, no time-out
  localparam logic [SYNC_W-1:0] SYNC_INIT = 4'h3;

  rsq_regs_s r_q;
  rsq_regs_s r_d;
  logic [SYNC_W-1:0] sy;
  logic supply_low;
  logic pin_low;
  logic wdt_rise;
  logic sys_src;
  logic in_port_rst;
  logic [CNT_W-1:0] hold_last;

  rsq_sync3 #(
    .W(SYNC_W),
    .INIT(SYNC_INIT)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({wdt_timeout, supply_brownout_detect, supply_above_por,
      reset_shared_port_pin_in}),
    .sync_out(sy)
  );

  assign supply_low = !sy[SY_POR] || sy[SY_BO];
  assign pin_low = !sy[SY_PIN];
  assign wdt_rise = sy[SY_WDT] && !r_q.wdt_prev;
  assign sys_src = supply_low || wdt_rise || (pin_low && !r_q.pin_gpio);
  assign in_port_rst = (r_q.st == RSQ_STARTUP) || (r_q.st == RSQ_HOLD);
  assign hold_last = xtal_opt_en ? HOLD_XTAL_LAST : HOLD_SHORT_LAST;

  always_comb
  begin
    r_d = r_q;
    r_d.cnt = r_q.cnt + CNT_W'(1);
    r_d.vec_rd = 1'b0;
    r_d.pc_load = 1'b0;
    r_d.wdt_prev = sy[SY_WDT];
    r_d.wdt_osc_on = 1'b1;
    if (pin_cfg_wr && r_q.st == RSQ_RUN)
    begin
      r_d.pin_gpio = pin_cfg_gpio;
    end
    r_d.pin_out = r_d.pin_gpio && pin_gpio_out_val;
    case (r_q.st)
      RSQ_STARTUP:
      begin
        if (supply_low)
        begin
          r_d.cnt = CNT_ZERO;
          r_d.stop = 1'b0;
        end
        else if (r_q.cnt == STARTUP_LAST)
        begin
          r_d.st = RSQ_HOLD;
          r_d.cnt = CNT_ZERO;
        end
      end
      RSQ_HOLD:
      begin
        if (supply_low)
        begin
          r_d.st = RSQ_STARTUP;
          r_d.cnt = CNT_ZERO;
          r_d.stop = 1'b0;
        end
        else if (r_q.cnt == hold_last)
        begin
          r_d.st = RSQ_PINREL;
          r_d.cnt = CNT_ZERO;
        end
      end
      RSQ_PINREL:
      begin
        if (supply_low)
        begin
          r_d.st = RSQ_STARTUP;
          r_d.cnt = CNT_ZERO;
          r_d.stop = 1'b0;
        end
        else if (r_q.cnt >= SETTLE_LAST)
        begin
          r_d.cnt = SETTLE_LAST;
          if (!(pin_low && !r_q.pin_gpio))
          begin
            r_d.st = RSQ_FETCH_HI;
            r_d.vec_addr = VEC_HI_ADDR;
            r_d.vec_rd = 1'b1;
          end
        end
      end
      RSQ_FETCH_HI:
      begin
        r_d.st = RSQ_FETCH_LO;
        r_d.vec_addr = VEC_LO_ADDR;
        r_d.vec_rd = 1'b1;
      end
      RSQ_FETCH_LO:
      begin
        r_d.st = RSQ_LOAD;
        r_d.vec_hi = vec_data;
      end
      RSQ_LOAD:
      begin
        r_d.st = RSQ_RUN;
        r_d.pc = {r_q.vec_hi, vec_data};
        r_d.pc_load = 1'b1;
      end
      RSQ_RUN:
      begin
        if (sys_src)
        begin
          r_d.st = RSQ_STARTUP;
          r_d.cnt = CNT_ZERO;
          r_d.stop = 1'b0;
        end
        else if (stop_exit)
        begin
          r_d.st = RSQ_STARTUP;
          r_d.cnt = CNT_ZERO;
          r_d.stop = 1'b1;
        end
      end
      default:
      begin
        r_d.st = RSQ_STARTUP;
        r_d.cnt = CNT_ZERO;
      end
    endcase
    // supply drop restarts the count from any reset phase, fetch included
    if (supply_low && r_q.st != RSQ_RUN)
    begin
      r_d.st = RSQ_STARTUP;
      r_d.cnt = CNT_ZERO;
      r_d.stop = 1'b0;
      r_d.vec_rd = 1'b0;
      r_d.pc_load = 1'b0;
    end
    // cleared on entry so the pin never drives high inside port reset
    if ((r_d.st == RSQ_STARTUP || r_d.st == RSQ_HOLD) && !r_d.stop)
    begin
      r_d.pin_gpio = 1'b0;
      r_d.pin_out = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q.st <= RSQ_STARTUP;
      r_q.cnt <= CNT_ZERO;
      r_q.stop <= 1'b0;
      r_q.pin_gpio <= 1'b0;
      r_q.pin_out <= 1'b0;
      r_q.vec_addr <= PC_RST;
      r_q.vec_rd <= 1'b0;
      r_q.vec_hi <= BYTE_RST;
      r_q.pc <= PC_RST;
      r_q.pc_load <= 1'b0;
      r_q.wdt_prev <= 1'b0;
      r_q.wdt_osc_on <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // reset level outputs
  assign cpu_reset = r_q.st != RSQ_RUN;
  assign periph_idle = r_q.st != RSQ_RUN;
  assign ctrl_reg_init = in_port_rst && !r_q.stop;
  assign wdt_oscillator_control_reg_init = in_port_rst;
  assign sysclk_ipo_sel = in_port_rst;
  assign port_reset = in_port_rst && !r_q.stop;
  assign gpio_force_input = port_reset;
  assign gpio_pullup_off = port_reset;
  assign gpio_altfn_off = port_reset;
  assign xtal_osc_run = xtal_opt_en;
  assign wdt_osc_run = r_q.wdt_osc_on;
  // pin: low while port reset, open-drain released otherwise unless gpio
  assign reset_shared_port_pin_out = r_q.pin_out;
  assign reset_shared_port_pin_oe_n = !(port_reset || r_q.pin_gpio);
  assign vec_addr = r_q.vec_addr;
  assign vec_rd = r_q.vec_rd;
  assign pc_value = r_q.pc;
  assign pc_load = r_q.pc_load;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  short_hold_a: assert property (
    (r_q.st == RSQ_HOLD && !xtal_opt_en && !supply_low && r_q.cnt == HOLD_SHORT_LAST)
    |=> (r_q.st == RSQ_PINREL && r_q.cnt == CNT_ZERO))
    else $error("short hold did not end after 66 cycles");

  xtal_hold_a: assert property (
    (r_q.st == RSQ_HOLD && xtal_opt_en && r_q.cnt < HOLD_XTAL_LAST)
    |=> (r_q.st == RSQ_HOLD || r_q.st == RSQ_STARTUP))
    else $error("crystal hold ended early");

  startup_end_a: assert property (
    (r_q.st == RSQ_STARTUP && !supply_low && r_q.cnt == STARTUP_LAST)
    |=> (r_q.st == RSQ_HOLD && r_q.cnt == CNT_ZERO))
    else $error("start-up interval wrong length");

  supply_restart_a: assert property (
    (cpu_reset && supply_low)
    |=> (r_q.st == RSQ_STARTUP && r_q.cnt == CNT_ZERO))
    else $error("supply low did not restart count");

  pin_wait_a: assert property (
    (r_q.st == RSQ_PINREL && r_q.cnt == SETTLE_LAST && pin_low && !r_q.pin_gpio
      && !supply_low)
    |=> (r_q.st == RSQ_PINREL && cpu_reset))
    else $error("left reset with pin asserted");

  stop_keep_a: assert property (
    (r_q.st == RSQ_RUN && stop_exit && !sys_src)
    |=> (!ctrl_reg_init && wdt_oscillator_control_reg_init && cpu_reset))
    else $error("stop recovery reset wrong registers");

  port_input_a: assert property (
    port_reset |-> (gpio_force_input && gpio_pullup_off && gpio_altfn_off))
    else $error("ports not forced to inputs");

  pin_drive_a: assert property (
    port_reset |-> (!reset_shared_port_pin_oe_n && reset_shared_port_pin_out == 1'b0))
    else $error("shared pin not driven low");

  vector_fetch_a: assert property (
    (r_q.st == RSQ_FETCH_HI) |-> (vec_addr == VEC_HI_ADDR && vec_rd)
    ##1 (vec_addr == VEC_LO_ADDR && vec_rd) ##2
    (pc_load && !cpu_reset && pc_value == {$past(vec_data, 2), $past(vec_data, 1)}))
    else $error("reset vector not loaded");

  pin_request_a: assert property (
    (r_q.st == RSQ_RUN && pin_low && !r_q.pin_gpio)
    |=> (r_q.st == RSQ_STARTUP && !r_q.stop))
    else $error("external pin reset ignored");

  pin_config_a: assert property (
    (r_q.st == RSQ_RUN && pin_cfg_wr && !sys_src)
    |=> (r_q.pin_gpio == $past(pin_cfg_gpio)))
    else $error("pin mode write not taken");
endmodule

// ==== design/rsq_pkg.sv ====
// Purpose: shared constants and types for the reset sequencer
// Assumes: clk is the internal precision oscillator clock at 125 MHz
// Notes: long hold count is also a top-level parameter
package rsq_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int IPO_STARTUP_NS = 4000;
  localparam int STARTUP_CYC = (IPO_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_SHORT_CYC = 66;
  localparam int HOLD_XTAL_DEF = 5000;
  localparam int PIN_SETTLE_CYC = 4;
  localparam int CNT_W = 13;
  localparam int SYNC_W = 4;
  localparam int SY_PIN = 0;
  localparam int SY_POR = 1;
  localparam int SY_BO = 2;
  localparam int SY_WDT = 3;
  localparam logic [15:0] VEC_HI_ADDR = 16'h0002;
  localparam logic [15:0] VEC_LO_ADDR = 16'h0003;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;

  typedef enum logic [2:0] {
    RSQ_STARTUP = 3'b000,
    RSQ_HOLD = 3'b001,
    RSQ_PINREL = 3'b010,
    RSQ_FETCH_HI = 3'b011,
    RSQ_FETCH_LO = 3'b100,
    RSQ_LOAD = 3'b101,
    RSQ_RUN = 3'b110
  } rsq_state_e;

  typedef struct packed {
    rsq_state_e st;
    logic [CNT_W-1:0] cnt;
    logic stop;
    logic pin_gpio;
    logic pin_out;
    logic [15:0] vec_addr;
    logic vec_rd;
    logic [7:0] vec_hi;
    logic [15:0] pc;
    logic pc_load;
    logic wdt_prev;
    logic wdt_osc_on;
  } rsq_regs_s;
endpackage

// ==== design/rsq_sync3.sv ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes: output moves only once stages two and three agree
module rsq_sync3
  import rsq_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // signals
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] val;
  } rsq_sync_s;

  rsq_sync_s s_q;
  rsq_sync_s s_d;

  always_comb
  begin
    s_d.ff1 = async_in;
    s_d.ff2 = s_q.ff1;
    s_d.ff3 = s_q.ff2;
    s_d.val = (s_q.ff2 & s_q.ff3) | (s_q.val & (s_q.ff2 | s_q.ff3));
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= {INIT, INIT, INIT, INIT};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.val;
endmodule

// ==== bench/rsq_board_model.sv ====
// Purpose: board reset line with pull-up and vector memory
// Assumes: vector memory answers one cycle after a read strobe
// Notes: invalid read data toggles so stale bytes never match
module rsq_board_model
  import rsq_pkg::*;
#(
  parameter logic [7:0] VEC_MSB = 8'h5a,
  parameter logic [7:0] VEC_LSB = 8'hc3
)
(
  // clock
  input wire logic clk,
  // reset line
  input wire logic ext_reset_req,
  input wire logic reset_shared_port_pin_out,
  input wire logic reset_shared_port_pin_oe_n,
  output logic reset_shared_port_pin_in,
  // vector memory
  input wire logic [15:0] vec_addr,
  input wire logic vec_rd,
  output logic [7:0] vec_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] data_q = 8'h00;

  // wired line: button or device pulls low, else pull-up
  assign reset_shared_port_pin_in = ~ext_reset_req &
    (reset_shared_port_pin_oe_n | reset_shared_port_pin_out);
  assign vec_data = data_q;

  always @(posedge clk)
  begin
    if (vec_rd === 1'b1)
      data_q <= (vec_addr === VEC_HI_ADDR) ? VEC_MSB :
        (vec_addr === VEC_LO_ADDR) ? VEC_LSB : ~data_q;
    else
      data_q <= ~data_q;
  end
endmodule

// ==== bench/tb_reset_sequencer.sv ====
// Purpose: self-checking bench for the reset sequencer
// Assumes: 125 MHz clock, crystal hold shortened to 80 cycles
// Notes: counts carry a few cycles of input sync slack
module tb_reset_sequencer
  import rsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int XT = 80;
  localparam int BASE = STARTUP_CYC + HOLD_SHORT_CYC;
  localparam logic [15:0] EXP_PC = 16'h5ac3;
  int miscompares = 0;
  int total_checks = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_above_por = 1'b1;
  logic supply_brownout_detect = 1'b0;
  logic wdt_timeout = 1'b0;
  logic stop_exit = 1'b0;
  logic xtal_opt_en = 1'b0;
  logic ext_reset_req = 1'b0;
  logic pin_cfg_wr = 1'b0;
  logic pin_cfg_gpio = 1'b0;
  logic pin_gpio_out_val = 1'b0;
  logic reset_shared_port_pin_in, reset_shared_port_pin_out, reset_shared_port_pin_oe_n;
  logic cpu_reset, periph_idle, ctrl_reg_init, wdt_oscillator_control_reg_init, sysclk_ipo_sel;
  logic port_reset, gpio_force_input, gpio_pullup_off, gpio_altfn_off;
  logic xtal_osc_run, wdt_osc_run, vec_rd, pc_load;
  logic [15:0] vec_addr, pc_value;
  logic [7:0] vec_data;

  rsq_reset_sequencer #(.HOLD_XTAL_CYC(XT)) uut (.clk, .rst_n, .supply_above_por,
    .supply_brownout_detect, .wdt_timeout, .stop_exit, .xtal_opt_en,
    .reset_shared_port_pin_in, .reset_shared_port_pin_out, .reset_shared_port_pin_oe_n,
    .pin_cfg_wr, .pin_cfg_gpio, .pin_gpio_out_val, .cpu_reset, .periph_idle,
    .ctrl_reg_init, .wdt_oscillator_control_reg_init, .sysclk_ipo_sel, .port_reset, .gpio_force_input,
    .gpio_pullup_off, .gpio_altfn_off, .xtal_osc_run, .wdt_osc_run, .vec_addr, .vec_rd,
    .vec_data, .pc_value, .pc_load);

  rsq_board_model board (.clk, .ext_reset_req, .reset_shared_port_pin_out,
    .reset_shared_port_pin_oe_n, .reset_shared_port_pin_in, .vec_addr, .vec_rd, .vec_data);

  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi)
    begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  task automatic count_reset(output int n);
    n = 0;
    while (cpu_reset !== 1'b0 && n < 8000)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic chk_hold(input logic sys);
    chk_bit(cpu_reset, 1'b1);
    chk_bit(periph_idle, 1'b1);
    chk_bit(xtal_osc_run, xtal_opt_en);
    chk_bit(wdt_osc_run, 1'b1);
    chk_bit(ctrl_reg_init, sys);
    chk_bit(wdt_oscillator_control_reg_init, 1'b1);
    chk_bit(sysclk_ipo_sel, 1'b1);
    chk_bit(port_reset, sys);
    chk_bit(gpio_force_input, sys);
    chk_bit(gpio_pullup_off, sys);
    chk_bit(gpio_altfn_off, sys);
    chk_bit(reset_shared_port_pin_oe_n, ~sys);
  endtask

  task automatic run_seq(input logic sys, input int lo, input int hi);
    int n;
    repeat (100) @(negedge clk);
    chk_hold(sys);
    count_reset(n);
    chk_cnt(n + 100, lo, hi);
    chk_bit(pc_load, 1'b1);
    chk_word(pc_value, EXP_PC);
    chk_bit(reset_shared_port_pin_oe_n, 1'b1);
  endtask

  task automatic t_gpio;
    @(posedge clk)
    begin
      pin_cfg_wr <= 1'b1;
      pin_cfg_gpio <= 1'b1;
    end
    @(posedge clk) pin_cfg_wr <= 1'b0;
    repeat (20) @(negedge clk);
    chk_bit(reset_shared_port_pin_oe_n, 1'b0);
    chk_bit(reset_shared_port_pin_out, 1'b0);
    chk_bit(cpu_reset, 1'b0);
    @(posedge clk) pin_gpio_out_val <= 1'b1;
    repeat (8) @(negedge clk);
    chk_bit(reset_shared_port_pin_out, 1'b1);
    @(posedge clk)
    begin
      pin_cfg_wr <= 1'b1;
      pin_cfg_gpio <= 1'b0;
    end
    @(posedge clk) pin_cfg_wr <= 1'b0;
    repeat (20) @(negedge clk);
    chk_bit(reset_shared_port_pin_oe_n, 1'b1);
    chk_bit(cpu_reset, 1'b0);
  endtask

  task automatic t_xtal;
    @(posedge clk)
    begin
      xtal_opt_en <= 1'b1;
      wdt_timeout <= 1'b1;
    end
    run_seq(1'b1, STARTUP_CYC + XT + 6, STARTUP_CYC + XT + 20);
    @(posedge clk)
    begin
      xtal_opt_en <= 1'b0;
      wdt_timeout <= 1'b0;
    end
  endtask

  task automatic t_stop;
    @(posedge clk) stop_exit <= 1'b1;
    @(posedge clk) stop_exit <= 1'b0;
    run_seq(1'b0, BASE + 6, BASE + 20);
  endtask

  task automatic t_supply;
    @(posedge clk) supply_above_por <= 1'b0;
    repeat (50) @(negedge clk);
    chk_bit(cpu_reset, 1'b1);
    @(posedge clk) supply_above_por <= 1'b1;
    run_seq(1'b1, BASE + 6, BASE + 20);
    @(posedge clk) supply_brownout_detect <= 1'b1;
    repeat (50) @(negedge clk);
    @(posedge clk) supply_brownout_detect <= 1'b0;
    run_seq(1'b1, BASE + 6, BASE + 20);
  endtask

  task automatic t_pin;
    int n;
    @(posedge clk) ext_reset_req <= 1'b1;
    repeat (100) @(negedge clk);
    chk_hold(1'b1);
    repeat (800) @(negedge clk);
    chk_bit(cpu_reset, 1'b1);
    @(posedge clk) ext_reset_req <= 1'b0;
    count_reset(n);
    chk_cnt(n, 1, 20);
    chk_word(pc_value, EXP_PC);
  endtask

  initial
  begin
    #400000;
    miscompares++;
    complete_run;
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    run_seq(1'b1, BASE + 6, BASE + 20);
    t_gpio;
    t_xtal;
    t_stop;
    t_supply;
    t_pin;
    complete_run;
  end
endmodule
